//--- irmf_filter.sv
// Overview of operation
// - Per-context descriptor pointer at base plus stride.
// - Bits 31..28 enable tags 11,10,01,00.
// - Cycle field starts context on equal count.
// - Sync field compared when wait-select is 11.
// - Tag-01 qualifier requires sync top bits 00.
// - Other tags unaffected by tag-01 qualifier.
// - Qualifier clear: only tag enables matter.
// - Channel field selects single accepted channel.
// - Multi-channel mode uses shared channel mask.
// - Cycle start enable clear request pulses on activation.
`timescale 1ns/1ns
`default_nettype none
module irmf_filter #(
   parameter int NUM_CTX = 4
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_reset_n,
   input  wire logic                i_reg_wr,
   input  wire logic                i_reg_rd,
   input  wire logic [15:0]         i_reg_addr,
   input  wire logic [31:0]         i_reg_wdata,
   output logic      [31:0]         o_reg_rdata,
   input  wire logic [NUM_CTX-1:0]  i_run,
   input  wire logic [NUM_CTX-1:0]  i_start_on_cycle_enable,
   input  wire logic [NUM_CTX-1:0]  i_multi_channel_receive,
   input  wire logic [63:0]         i_channel_mask,
   input  wire logic [NUM_CTX*2-1:0] i_wait_select,
   input  wire logic                i_cycle_start,
   input  wire logic [12:0]         i_cycle_count,
   input  wire irmf_pkg::irmf_pkt_t i_pkt,
   output logic      [NUM_CTX-1:0]  o_accept,
   output logic      [NUM_CTX-1:0]  o_active,
   output logic      [NUM_CTX-1:0]  o_cycle_enable_clear
);
   logic [31:0]           ptr_r      [NUM_CTX];
   logic [31:0]           match_r    [NUM_CTX];
   irmf_pkg::irmf_state_t state_r    [NUM_CTX];
   irmf_pkg::irmf_state_t state_nxt  [NUM_CTX];
   logic [NUM_CTX-1:0]    ptr_hit;
   logic [NUM_CTX-1:0]    match_hit;
   logic [NUM_CTX-1:0]    cycle_hit;
   logic [NUM_CTX-1:0]    chan_ok;
   logic [NUM_CTX-1:0]    sync_ok;
   logic [NUM_CTX-1:0]    tag_pass;
   logic [NUM_CTX-1:0]    clear_nxt;
   logic [NUM_CTX-1:0]    active_nxt;
   logic [NUM_CTX-1:0]    accept_nxt;

   function automatic logic [15:0] ctx_addr(input logic [15:0] base, input int n);
      ctx_addr = base + 16'(n) * irmf_pkg::IRMF_CTX_STRIDE;
   endfunction

   function automatic logic addr_hit(input logic [15:0] addr,
                                     input logic [15:0] base,
                                     input int          n);
      addr_hit = (addr == ctx_addr(base, n));
   endfunction

   function automatic logic [12:0] cycle_field(
      input logic [31:0] m);
      cycle_field = m[irmf_pkg::IRMF_CYC_HI:irmf_pkg::IRMF_CYC_LO];
   endfunction

   function automatic logic [3:0] sync_field(
      input logic [31:0] m);
      sync_field = m[irmf_pkg::IRMF_SYNC_HI:irmf_pkg::IRMF_SYNC_LO];
   endfunction

   function automatic logic [5:0] chan_field(
      input logic [31:0] m);
      chan_field = m[irmf_pkg::IRMF_CHAN_HI:irmf_pkg::IRMF_CHAN_LO];
   endfunction

   function automatic logic tag_ok(input logic [31:0]         m,
                                   input irmf_pkg::irmf_pkt_t p);
      logic en;
      en = m[irmf_pkg::IRMF_TAG00_BIT + int'(p.tag)];
      if (p.tag == irmf_pkg::IRMF_TAG_01 && m[irmf_pkg::IRMF_SYNCQ_BIT]) begin
         en = en && (p.sync[3:2] == irmf_pkg::IRMF_SYNC_TOP_OK);
      end
      tag_ok = en;
   endfunction

   // Address and cycle decode shared by the register and start logic.
   always_comb begin
      for (int n = 0; n < NUM_CTX; n++) begin
         ptr_hit[n]   = addr_hit(i_reg_addr, irmf_pkg::IRMF_PTR_BASE, n);
         match_hit[n] = addr_hit(i_reg_addr, irmf_pkg::IRMF_MATCH_BASE, n);
         cycle_hit[n] = i_cycle_start && (i_cycle_count == cycle_field(match_r[n]));
      end
   end

   always_ff @(posedge i_sys_clk) begin
      for (int n = 0; n < NUM_CTX; n++) begin
         if (!i_reset_n) begin
            ptr_r[n] <= '0;
         end else if (i_reg_wr && ptr_hit[n]) begin
            ptr_r[n] <= i_reg_wdata;
         end
      end
   end

   // Reserved match bits are never stored, so they always read back zero.
   always_ff @(posedge i_sys_clk) begin
      for (int n = 0; n < NUM_CTX; n++) begin
         if (!i_reset_n) begin
            match_r[n] <= '0;
         end else if (i_reg_wr && match_hit[n]) begin
            match_r[n] <= i_reg_wdata & ~irmf_pkg::IRMF_MATCH_RSV;
         end
      end
   end

   always_comb begin
      o_reg_rdata = '0;
      for (int n = 0; n < NUM_CTX; n++) begin
         if (i_reg_rd && ptr_hit[n]) begin
            o_reg_rdata = ptr_r[n];
         end
         if (i_reg_rd && match_hit[n]) begin
            o_reg_rdata = match_r[n];
         end
      end
   end

   // A stopped context always falls back to idle, whatever its state.
   always_comb begin
      for (int n = 0; n < NUM_CTX; n++) begin
         state_nxt[n] = state_r[n];
         clear_nxt[n] = 1'b0;
         if (!i_run[n]) begin
            state_nxt[n] = irmf_pkg::IRMF_IDLE;
         end else begin
            case (state_r[n])
               irmf_pkg::IRMF_IDLE: begin
                  if (i_start_on_cycle_enable[n]) begin
                     state_nxt[n] = irmf_pkg::IRMF_WAITCYC;
                  end else begin
                     state_nxt[n] = irmf_pkg::IRMF_ACTIVE;
                  end
               end
               irmf_pkg::IRMF_WAITCYC: begin
                  if (cycle_hit[n]) begin
                     state_nxt[n] = irmf_pkg::IRMF_ACTIVE;
                     clear_nxt[n] = 1'b1;
                  end
               end
               irmf_pkg::IRMF_ACTIVE: state_nxt[n] = irmf_pkg::IRMF_ACTIVE;
               default: state_nxt[n] = irmf_pkg::IRMF_IDLE;
            endcase
         end
         active_nxt[n] = (state_r[n] == irmf_pkg::IRMF_ACTIVE);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      for (int n = 0; n < NUM_CTX; n++) begin
         if (!i_reset_n) begin
            state_r[n] <= irmf_pkg::IRMF_IDLE;
         end else begin
            state_r[n] <= state_nxt[n];
         end
      end
   end

   // The clear request is a single-cycle pulse toward context control.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_cycle_enable_clear <= '0;
      end else begin
         o_cycle_enable_clear <= clear_nxt;
      end
   end

   // Channel qualification, either one channel or the shared mask.
   always_comb begin
      for (int n = 0; n < NUM_CTX; n++) begin
         if (i_multi_channel_receive[n]) begin
            chan_ok[n] = i_channel_mask[i_pkt.channel];
         end else begin
            chan_ok[n] = (i_pkt.channel == chan_field(match_r[n]));
         end
      end
   end

   // Apart from the tag-01 qualifier, the sync value only matters while the descriptor waits on it.
   always_comb begin
      for (int n = 0; n < NUM_CTX; n++) begin
         if (i_wait_select[2*n +: 2] == irmf_pkg::IRMF_WAIT_SYNC) begin
            sync_ok[n] = (i_pkt.sync == sync_field(match_r[n]));
         end else begin
            sync_ok[n] = 1'b1;
         end
      end
   end

   always_comb begin
      for (int n = 0; n < NUM_CTX; n++) begin
         tag_pass[n]   = tag_ok(match_r[n], i_pkt);
         accept_nxt[n] = i_pkt.valid && (state_r[n] == irmf_pkg::IRMF_ACTIVE) &&
                         chan_ok[n] && sync_ok[n] && tag_pass[n];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_accept <= '0;
      end else begin
         o_accept <= accept_nxt;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_active <= '0;
      end else begin
         o_active <= active_nxt;
      end
   end
endmodule
`default_nettype wire

//--- irmf_pkg.sv
package irmf_pkg;
   localparam logic [15:0] IRMF_PTR_BASE     = 16'h040c;
   localparam logic [15:0] IRMF_MATCH_BASE   = 16'h410c;
   localparam logic [15:0] IRMF_CTX_STRIDE   = 16'h0020;
   localparam int          IRMF_TAG11_BIT    = 31;
   localparam int          IRMF_TAG10_BIT    = 30;
   localparam int          IRMF_TAG01_BIT    = 29;
   localparam int          IRMF_TAG00_BIT    = 28;
   localparam int          IRMF_CYC_HI       = 24;
   localparam int          IRMF_CYC_LO       = 12;
   localparam int          IRMF_SYNC_HI      = 11;
   localparam int          IRMF_SYNC_LO      = 8;
   localparam int          IRMF_SYNCQ_BIT    = 6;
   localparam int          IRMF_CHAN_HI      = 5;
   localparam int          IRMF_CHAN_LO      = 0;
   localparam logic [31:0] IRMF_MATCH_RSV    = 32'h0e000080;
   localparam logic [1:0]  IRMF_WAIT_SYNC    = 2'h3;
   localparam logic [1:0]  IRMF_TAG_01       = 2'h1;
   localparam logic [1:0]  IRMF_SYNC_TOP_OK  = 2'h0;

   typedef struct packed {
      logic       valid;
      logic [5:0] channel;
      logic [1:0] tag;
      logic [3:0] sync;
   } irmf_pkt_t;

   typedef enum logic [1:0] {
      IRMF_IDLE    = 2'b00,
      IRMF_WAITCYC = 2'b01,
      IRMF_ACTIVE  = 2'b10
   } irmf_state_t;
endpackage

//--- irmf_pkt_source.sv
`timescale 1ns/1ns
`default_nettype none
module irmf_pkt_source (
   input  wire logic          i_sys_clk,
   output var irmf_pkg::irmf_pkt_t o_pkt
);
   initial o_pkt = '0;
   task automatic send(input logic [11:0] f);
      @(negedge i_sys_clk) o_pkt = {1'b1, f};
      @(negedge i_sys_clk) o_pkt = {1'b0, ~f};
   endtask
endmodule
`default_nettype wire

//--- irmf_filter_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module irmf_filter_chk #(
   parameter int NUM_CTX = 4
) (
   input wire logic                i_sys_clk,
   input wire logic                i_reset_n,
   input wire logic                i_reg_rd,
   input wire logic [15:0]         i_reg_addr,
   input wire logic [31:0]         o_reg_rdata,
   input wire logic [NUM_CTX-1:0]  i_run,
   input wire logic [NUM_CTX-1:0]  i_start_on_cycle_enable,
   input wire logic                i_cycle_start,
   input wire irmf_pkg::irmf_pkt_t i_pkt,
   input wire logic [NUM_CTX-1:0]  o_accept,
   input wire logic [NUM_CTX-1:0]  o_active,
   input wire logic [NUM_CTX-1:0]  o_cycle_enable_clear
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   sequence run_low_s; !i_run[0] [*2]; endsequence
   sequence hit_s; $past(i_cycle_start) || $past(i_cycle_start, 2); endsequence
   accept_cause_a: assert property (o_accept[0] |-> $past(i_pkt.valid) && $past(i_run[0], 2))
      else $error("accept without packet");
   idle_drop_a: assert property (run_low_s |=> !o_active[0])
      else $error("active while stopped");
   active_run_a: assert property (o_active[0] |-> $past(i_run[0], 2))
      else $error("active without run");
   clear_cause_a: assert property (o_cycle_enable_clear[0] |-> hit_s)
      else $error("clear without cycle start");
   clear_pulse_a: assert property (o_cycle_enable_clear[0] |=> !o_cycle_enable_clear[0])
      else $error("clear too long");
   clear_active_a: assert property (o_cycle_enable_clear[0] |-> ##[0:2] o_active[0])
      else $error("clear without start");
   read_gate_a: assert property (!i_reg_rd |-> o_reg_rdata == '0)
      else $error("read data without read");
   reserved_zero_a: assert property (i_reg_rd && i_reg_addr == 16'h410c
      |-> (o_reg_rdata & irmf_pkg::IRMF_MATCH_RSV) == '0)
      else $error("reserved bits set");
endmodule
bind irmf_filter irmf_filter_chk #(.NUM_CTX(NUM_CTX)) u_chk (.*);
`default_nettype wire

//--- irmf_filter_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin num_errors++; $display("wrong value %0t %h %h", $time, a, b); end end
module irmf_filter_test;
   logic                clk = 0, rst_n = 0, wr = 0, rd = 0, cs = 0, run = 0, en = 0, mc = 0;
   logic                acc, act, clr, seen;
   logic [1:0]          ws = '0;
   logic [12:0]         cc = '0;
   logic [15:0]         ad = '0;
   logic [31:0]         wd = '0, rdata;
   irmf_pkg::irmf_pkt_t pkt;
   int                  num_errors = 0, n_checks = 0, cyc = 0;
   logic [47:0]         rows [15] = '{48'h80000005_170_2, 48'h40000005_160_2,
      48'h20000005_150_2, 48'h10000005_140_2, 48'h70000005_170_0, 48'hf0000005_1b0_0,
      48'h20000045_154_0, 48'h20000045_153_2, 48'h10000045_14c_2, 48'h20000005_15c_2,
      48'hf0000a05_17a_e, 48'hf0000a05_17b_c, 48'hf0000a05_17b_2, 48'hf0000005_240_3,
      48'hf0000005_140_1};
   always #20 clk = ~clk;
   irmf_pkt_source SRC (.i_sys_clk(clk), .o_pkt(pkt));
   irmf_filter #(.NUM_CTX(1)) DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_run(run),
      .i_start_on_cycle_enable(en), .i_multi_channel_receive(mc), .i_channel_mask(64'h200),
      .i_wait_select(ws), .i_cycle_start(cs), .i_cycle_count(cc), .i_pkt(pkt),
      .o_accept(acc), .o_active(act), .o_cycle_enable_clear(clr));
   task automatic results;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wreg(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk) {wr, ad, wd} = {1'b1, a, d};
      @(negedge clk) wr = 0;
   endtask
   task automatic rreg(input logic [15:0] a, input logic [31:0] e);
      @(negedge clk) {rd, ad} = {1'b1, a};
      #1 `CHK(rdata, e)
      rd = 0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1;
      rreg(16'h410c, '0);
      wreg(16'h040c, 32'h89abcdef);
      rreg(16'h040c, 32'h89abcdef);
      wreg(16'h410c, '1);
      rreg(16'h410c, 32'hf1ffff7f);
      rreg(16'h042c, '0);
      run = 1;
      foreach (rows[i]) begin
         ws = rows[i][3:2];
         mc = rows[i][0];
         wreg(16'h410c, rows[i][47:16]);
         SRC.send(rows[i][15:4]);
         `CHK(acc, rows[i][1])
      end
      {run, ws, mc} = '0;
      wreg(16'h410c, 32'h10123005);
      {en, run} = 2'b11;
      @(negedge clk) {cs, cc} = {1'b1, 13'h0122};
      @(negedge clk) cs = 0;
      repeat (3) @(negedge clk);
      `CHK(act, 1'b0)
      {cs, cc, seen} = {1'b1, 13'h0123, 1'b0};
      repeat (4) @(negedge clk) {cs, seen} = {1'b0, seen | clr};
      en = 0;
      `CHK(seen, 1'b1)
      `CHK(act, 1'b1)
      results();
   end
endmodule
`default_nettype wire
